// file: inc/rec_consts.vh
// register offsets, field positions and reset values for regulator enable control
`ifndef REC_CONSTS_VH
`define REC_CONSTS_VH

// register offsets (printed offsets kept as addresses)
`define REC_ADDR_W 12
`define REC_OFS_PUMP 12'h200
`define REC_OFS_CORE_A 12'h210
`define REC_OFS_CORE_B 12'h212
`define REC_OFS_MIC_REG 12'h213
`define REC_OFS_BIAS1 12'h218
`define REC_OFS_ISOLATE 12'h2cb
`define REC_OFS_PAD 12'hc20

// common bit positions
`define REC_BIT_ENA 0
`define REC_BIT_BYPASS 1
`define REC_BIT_DISCH 2
`define REC_BIT_RATE 3
`define REC_BIT_EXT_CAP 15
`define REC_BIT_PD 15
`define REC_BIT_PU 14
`define REC_BIT_HI_PWR 0
`define REC_BIT_ISOLATE 0
`define REC_VSEL_HI 10
`define REC_VSEL_LO 5
`define REC_LVL_HI 8
`define REC_LVL_LO 5

// reset values
`define REC_RST_PUMP 16'h0006
`define REC_RST_CORE_A 16'h00c4
`define REC_RST_CORE_B 16'h0001
`define REC_RST_MIC_REG 16'h0344
`define REC_RST_BIAS1 16'h01a6
`define REC_RST_ISOLATE 16'h0000
`define REC_RST_PAD 16'h8000
`define REC_RST_MIC_VSEL 6'h1a
`define REC_RDATA_IDLE 16'h0000

// writable bit masks; other bits read as zero
`define REC_MSK_PUMP 16'h0007
`define REC_MSK_CORE_A 16'h07e7
`define REC_MSK_CORE_B 16'h0001
`define REC_MSK_MIC_REG 16'h07e4
`define REC_MSK_BIAS1 16'h81ef
`define REC_MSK_ISOLATE 16'h0001
`define REC_MSK_PAD 16'hc000

// voltage codes
`define REC_CORE_VSEL_MAX 6'h06
`define REC_CORE_VSEL_1V8 6'h12
`define REC_MIC_VSEL_MAX 6'h1f
`define REC_BIAS_LVL_MAX 4'hd

`endif

// file: logic/rec_regulator_enable_control.v
// regulator enable control: register file, enable logic and pin keeper
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "rec_consts.vh"

// Operation
// - pin or software bit enables core regulator
// - core off only when both sources low
// - core bypass honoured only while enabled
// - disabled core output discharged when bit set
// - high power forces 1.8V, ignores select
// - core select 0.9V base, 50mV steps, reserved
// - mic supply select 1.7V base, 1Fh 3.3V
// - pump enable drives pump and mic regulator
// - pump bypass needs pump enable also set
// - disabled pump output discharged when bit set
// - disabled mic regulator discharged when bit set
// - bias1 capacitor setting in regulator mode
// - bias1 level 1.5V base, Dh-Fh 2.8V
// - bias1 ramp rate applies in bypass mode
// - core regulator off means sleep entry
// - pin pulldown at reset, keeper when both
// - isolate bit clears after wake-up
module rec_regulator_enable_control (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // register port
  input wire [11:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [15:0] reg_rdata,
  // enable pin, sampled; pin_driven low when host tristates it
  input wire core_reg_enable_pin,
  input wire core_reg_enable_pin_driven,
  // wake-up event from the sleep controller, same clock
  input wire wake_done,
  // core regulator controls
  output reg core_reg_on,
  output reg core_reg_bypass,
  output reg core_reg_discharge,
  output reg [5:0] core_reg_voltage_code,
  // pump and mic supply controls
  output reg mic_pump_on,
  output reg mic_pump_bypass,
  output reg mic_pump_discharge,
  output reg mic_supply_discharge,
  output reg [5:0] mic_supply_voltage_code,
  // bias channel 1 controls
  output reg bias1_ext_capacitor,
  output reg [3:0] bias1_level,
  output reg bias1_ramp_rate,
  // sleep and pad controls
  output reg sleep_request,
  output reg core_domain_isolate,
  output reg enable_pin_pulldown,
  output reg enable_pin_pullup
);

  wire [15:0] pump_r;
  wire [15:0] core_a_r;
  wire [15:0] core_b_r;
  wire [15:0] mic_reg_r;
  wire [15:0] bias1_r;
  reg [15:0] iso_r;
  reg [15:0] next_iso;
  wire [15:0] pad_r;
  reg pin_meta;
  reg pin_sync;
  reg drv_meta;
  reg drv_sync;
  reg pin_kept;
  reg next_pin_kept;
  reg core_on_q;
  reg [15:0] next_rdata;
  reg pin_level;
  reg core_enable;
  wire [5:0] core_vsel;
  wire [3:0] lvl_raw;

  assign core_vsel = core_a_r[`REC_VSEL_HI:`REC_VSEL_LO];
  assign lvl_raw = bias1_r[`REC_LVL_HI:`REC_LVL_LO];

  // two-stage synchronisers for the pin and its drive state
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      drv_meta <= 1'b0;
      drv_sync <= 1'b0;
    end
    else
    begin
      pin_meta <= core_reg_enable_pin;
      pin_sync <= pin_meta;
      drv_meta <= core_reg_enable_pin_driven;
      drv_sync <= drv_meta;
    end
  end

  // effective pin level: keeper, pull-up or pull-down when undriven
  always @*
  begin
    if (drv_sync)
      pin_level = pin_sync;
    else if (pad_r[`REC_BIT_PD] && pad_r[`REC_BIT_PU])
      pin_level = pin_kept;
    else if (pad_r[`REC_BIT_PU])
      pin_level = 1'b1;
    else
      pin_level = 1'b0;
  end

  // core enable is the OR of pin and software bit
  always @*
  begin
    core_enable = pin_level | core_a_r[`REC_BIT_ENA];
  end

  // software-writable control registers
  rec_ctrl_reg #(
    .ADDR(`REC_OFS_PUMP),
    .RST(`REC_RST_PUMP),
    .MSK(`REC_MSK_PUMP)
  ) pump_reg_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .value(pump_r)
  );

  rec_ctrl_reg #(
    .ADDR(`REC_OFS_CORE_A),
    .RST(`REC_RST_CORE_A),
    .MSK(`REC_MSK_CORE_A)
  ) core_a_reg_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .value(core_a_r)
  );

  rec_ctrl_reg #(
    .ADDR(`REC_OFS_CORE_B),
    .RST(`REC_RST_CORE_B),
    .MSK(`REC_MSK_CORE_B)
  ) core_b_reg_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .value(core_b_r)
  );

  rec_ctrl_reg #(
    .ADDR(`REC_OFS_MIC_REG),
    .RST(`REC_RST_MIC_REG),
    .MSK(`REC_MSK_MIC_REG)
  ) mic_reg_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .value(mic_reg_r)
  );

  rec_ctrl_reg #(
    .ADDR(`REC_OFS_BIAS1),
    .RST(`REC_RST_BIAS1),
    .MSK(`REC_MSK_BIAS1)
  ) bias1_reg_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .value(bias1_r)
  );

  rec_ctrl_reg #(
    .ADDR(`REC_OFS_PAD),
    .RST(`REC_RST_PAD),
    .MSK(`REC_MSK_PAD)
  ) pad_reg_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .value(pad_r)
  );

  // isolate bit; wake-up clear wins over a same-cycle write
  always @*
  begin
    next_iso = iso_r;
    if (reg_write && (reg_addr == `REC_OFS_ISOLATE))
      next_iso = reg_wdata & `REC_MSK_ISOLATE;
    if (wake_done)
      next_iso[`REC_BIT_ISOLATE] = 1'b0;
  end

  // isolate register storage
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      iso_r <= `REC_RST_ISOLATE;
    else
      iso_r <= next_iso;
  end

  // read mux; unmapped addresses read zero
  always @*
  begin
    case (reg_addr)
      `REC_OFS_PUMP: next_rdata = pump_r;
      `REC_OFS_CORE_A: next_rdata = core_a_r;
      `REC_OFS_CORE_B: next_rdata = core_b_r;
      `REC_OFS_MIC_REG: next_rdata = mic_reg_r;
      `REC_OFS_BIAS1: next_rdata = bias1_r;
      `REC_OFS_ISOLATE: next_rdata = iso_r;
      `REC_OFS_PAD: next_rdata = pad_r;
      default: next_rdata = `REC_RDATA_IDLE;
    endcase
  end

  // read data stands one cycle after the strobe only
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= `REC_RDATA_IDLE;
    else if (reg_read)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= `REC_RDATA_IDLE;
  end

  // keeper remembers last driven level
  always @*
  begin
    if (drv_sync)
      next_pin_kept = pin_sync;
    else
      next_pin_kept = pin_kept;
  end

  // keeper storage; idles low like the reset pull-down
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      pin_kept <= 1'b0;
    else
      pin_kept <= next_pin_kept;
  end

  // registered analogue controls
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_reg_on <= 1'b0;
      core_on_q <= 1'b0;
      core_reg_bypass <= 1'b0;
      core_reg_discharge <= 1'b1;
      core_reg_voltage_code <= `REC_CORE_VSEL_1V8;
      mic_pump_on <= 1'b0;
      mic_pump_bypass <= 1'b0;
      mic_pump_discharge <= 1'b1;
      mic_supply_discharge <= 1'b1;
      mic_supply_voltage_code <= `REC_RST_MIC_VSEL;
      bias1_ext_capacitor <= 1'b0;
      bias1_level <= `REC_BIAS_LVL_MAX;
      bias1_ramp_rate <= 1'b0;
      sleep_request <= 1'b0;
      core_domain_isolate <= 1'b0;
      enable_pin_pulldown <= 1'b1;
      enable_pin_pullup <= 1'b0;
    end
    else
    begin
      core_reg_on <= core_enable;
      core_on_q <= core_enable;
      core_reg_bypass <= core_enable & core_a_r[`REC_BIT_BYPASS];
      core_reg_discharge <= ~core_enable & core_a_r[`REC_BIT_DISCH];
      // high power forces 1.8V code; reserved codes clamp to top
      if (core_b_r[`REC_BIT_HI_PWR])
        core_reg_voltage_code <= `REC_CORE_VSEL_1V8;
      else if (core_vsel > `REC_CORE_VSEL_MAX)
        core_reg_voltage_code <= `REC_CORE_VSEL_MAX;
      else
        core_reg_voltage_code <= core_vsel;
      mic_pump_on <= pump_r[`REC_BIT_ENA];
      mic_pump_bypass <= pump_r[`REC_BIT_ENA] & pump_r[`REC_BIT_BYPASS];
      mic_pump_discharge <= ~pump_r[`REC_BIT_ENA] & pump_r[`REC_BIT_DISCH];
      mic_supply_discharge <= ~pump_r[`REC_BIT_ENA] & mic_reg_r[`REC_BIT_DISCH];
      if (mic_reg_r[`REC_VSEL_HI:`REC_VSEL_LO] > `REC_MIC_VSEL_MAX)
        mic_supply_voltage_code <= `REC_MIC_VSEL_MAX;
      else
        mic_supply_voltage_code <= mic_reg_r[`REC_VSEL_HI:`REC_VSEL_LO];
      bias1_ext_capacitor <= bias1_r[`REC_BIT_EXT_CAP];
      bias1_level <= (lvl_raw > `REC_BIAS_LVL_MAX) ? `REC_BIAS_LVL_MAX : lvl_raw;
      bias1_ramp_rate <= bias1_r[`REC_BIT_RATE];
      // sleep entry on falling core enable
      if (core_on_q & ~core_enable)
        sleep_request <= 1'b1;
      else if (core_enable)
        sleep_request <= 1'b0;
      core_domain_isolate <= iso_r[`REC_BIT_ISOLATE];
      enable_pin_pulldown <= pad_r[`REC_BIT_PD];
      enable_pin_pullup <= pad_r[`REC_BIT_PU];
    end
  end

endmodule // rec_regulator_enable_control

// one control register: reset value, writable mask, address decode
module rec_ctrl_reg #(
  parameter [11:0] ADDR = 12'h000,
  parameter [15:0] RST = 16'h0000,
  parameter [15:0] MSK = 16'hffff
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // register port
  input wire [11:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_write,
  // stored value
  output reg [15:0] value
);

  reg [15:0] next_value;

  // write decode; reserved bits are stored as zero
  always @*
  begin
    if (reg_write && (reg_addr == ADDR))
      next_value = reg_wdata & MSK;
    else
      next_value = value;
  end

  // storage with the field defaults on reset
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      value <= RST;
    else
      value <= next_value;
  end

endmodule // rec_ctrl_reg
`default_nettype wire

// file: sim/rec_host_model.sv
// host model driving the core regulator enable pin
`timescale 1ns/1ps
`default_nettype none
module rec_host_model (
  // clock
  input wire logic sys_clk,
  // bench commands
  input wire logic drive_level,
  input wire logic drive_on,
  // enable pin
  output logic core_reg_enable_pin = 1'b0,
  output logic core_reg_enable_pin_driven = 1'b1
);
  // released pin toggles each cycle, never a stable last value
  always @(posedge sys_clk)
  begin
    core_reg_enable_pin_driven <= drive_on;
    core_reg_enable_pin <= drive_on ? drive_level : ~core_reg_enable_pin;
  end
endmodule // rec_host_model
`default_nettype wire

// file: sim/rec_regulator_enable_control_sva.sv
// checker for regulator enable control outputs
`timescale 1ns/1ps
`default_nettype none
module rec_regulator_enable_control_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // watched ports
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic core_reg_enable_pin,
  input wire logic core_reg_enable_pin_driven,
  input wire logic core_reg_on,
  input wire logic core_reg_bypass,
  input wire logic core_reg_discharge,
  input wire logic [5:0] core_reg_voltage_code,
  input wire logic mic_pump_on,
  input wire logic mic_pump_bypass,
  input wire logic mic_pump_discharge,
  input wire logic mic_supply_discharge,
  input wire logic [5:0] mic_supply_voltage_code,
  input wire logic [3:0] bias1_level,
  input wire logic sleep_request
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  pin_enable_a: assert property (
    (core_reg_enable_pin && core_reg_enable_pin_driven) [*4] |-> core_reg_on)
    else $error("pin high but core off");
  bypass_needs_on_a: assert property (core_reg_bypass |-> core_reg_on)
    else $error("core bypass while off");
  discharge_off_a: assert property (core_reg_discharge |-> !core_reg_on)
    else $error("core discharge while on");
  core_code_a: assert property (
    core_reg_voltage_code <= 6'h06 || core_reg_voltage_code == 6'h12)
    else $error("core code out of range");
  mic_code_a: assert property (mic_supply_voltage_code <= 6'h1f)
    else $error("mic code out of range");
  pump_bypass_a: assert property (mic_pump_bypass |-> mic_pump_on)
    else $error("pump bypass while off");
  pump_disch_a: assert property (
    (mic_pump_discharge || mic_supply_discharge) |-> !mic_pump_on)
    else $error("discharge while pump on");
  bias_level_a: assert property (bias1_level <= 4'hd)
    else $error("bias level above top");
  sleep_entry_a: assert property ($fell(core_reg_on) |-> ##[0:2] sleep_request)
    else $error("no sleep after core off");
  rdata_idle_a: assert property (!reg_read |=> reg_rdata == 16'h0000)
    else $error("read data outside slot");
  cover property (core_reg_bypass);
  cover property (mic_pump_bypass);
  cover property (sleep_request);
endmodule // rec_regulator_enable_control_sva
bind rec_regulator_enable_control rec_regulator_enable_control_sva
  rec_regulator_enable_control_sva_i (.*);
`default_nettype wire

// file: sim/rec_regulator_enable_control_tb.sv
// testbench for regulator enable control
`timescale 1ns/1ps
`default_nettype none
`include "rec_consts.vh"
module rec_regulator_enable_control_tb;
  logic sys_clk = 0, rst_n = 0, reg_write = 0, reg_read = 0, wake_done = 0, lvl = 0, drv = 1;
  logic [11:0] reg_addr = 12'h000;
  logic [15:0] reg_wdata = 16'h0000;
  wire [15:0] reg_rdata;
  wire [5:0] core_reg_voltage_code, mic_supply_voltage_code;
  wire [3:0] bias1_level;
  wire core_reg_enable_pin, core_reg_enable_pin_driven, core_reg_on, core_reg_bypass;
  wire core_reg_discharge, mic_pump_on, mic_pump_bypass, mic_pump_discharge;
  wire mic_supply_discharge, bias1_ext_capacitor, bias1_ramp_rate, sleep_request;
  wire core_domain_isolate, enable_pin_pulldown, enable_pin_pullup;
  int failures = 0, check_count = 0, cyc = 0;
  logic [11:0] ofs [5] = '{`REC_OFS_PUMP, `REC_OFS_CORE_A, `REC_OFS_CORE_B,
    `REC_OFS_MIC_REG, `REC_OFS_BIAS1};
  logic [15:0] rv [5] = '{`REC_RST_PUMP, `REC_RST_CORE_A, `REC_RST_CORE_B,
    `REC_RST_MIC_REG, `REC_RST_BIAS1};
  logic [15:0] msk [5] = '{`REC_MSK_PUMP, `REC_MSK_CORE_A, `REC_MSK_CORE_B,
    `REC_MSK_MIC_REG, `REC_MSK_BIAS1};
  rec_regulator_enable_control rec_regulator_enable_control_i (.*);
  rec_host_model rec_host_model_i (.sys_clk(sys_clk), .drive_level(lvl), .drive_on(drv),
    .core_reg_enable_pin(core_reg_enable_pin),
    .core_reg_enable_pin_driven(core_reg_enable_pin_driven));
  // clock and hang guard
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      final_report;
    end
  end
  task automatic final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // main sequence
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) rd(ofs[i], rv[i]);
    rd(12'h2ff, 16'h0000);
    chk({8'h00, core_reg_discharge, enable_pin_pulldown, core_reg_voltage_code}, 16'h00d2);
    for (int i = 0; i < 5; i++)
    begin
      wr(ofs[i], 16'hffff);
      rd(ofs[i], msk[i]);
    end
    w(2);
    chk({core_reg_on, core_reg_bypass, core_reg_discharge, mic_pump_on, mic_pump_bypass,
      mic_pump_discharge, mic_supply_discharge, bias1_ext_capacitor, bias1_ramp_rate,
      sleep_request, mic_supply_voltage_code}, 16'hd99f);
    chk({6'h00, bias1_level, core_reg_voltage_code}, 16'h0352);
    wr(`REC_OFS_CORE_B, 16'h0000);
    w(2);
    chk({10'h000, core_reg_voltage_code}, 16'h0006);
    wr(`REC_OFS_CORE_A, 16'h0085);
    w(2);
    chk({10'h000, core_reg_voltage_code}, 16'h0004);
    wr(`REC_OFS_PUMP, 16'h0006);
    wr(`REC_OFS_CORE_A, 16'h0006);
    w(2);
    chk({8'h00, core_reg_on, core_reg_bypass, core_reg_discharge, mic_pump_on, mic_pump_bypass,
      mic_pump_discharge, mic_supply_discharge, sleep_request}, 16'h0027);
    wr(`REC_OFS_PUMP, 16'h0000);
    wr(`REC_OFS_CORE_A, 16'h0000);
    wr(`REC_OFS_MIC_REG, 16'h0000);
    w(2);
    chk({13'h0000, core_reg_discharge, mic_pump_discharge, mic_supply_discharge}, 16'h0000);
    @(posedge sys_clk) lvl <= 1'b1;
    w(5);
    chk({14'h0000, core_reg_on, sleep_request}, 16'h0002);
    wr(`REC_OFS_PAD, 16'hc000);
    @(posedge sys_clk) drv <= 1'b0;
    w(8);
    chk({14'h0000, core_reg_on, enable_pin_pullup}, 16'h0003);
    @(posedge sys_clk) drv <= 1'b1;
    lvl <= 1'b0;
    w(5);
    chk({15'h0000, core_reg_on}, 16'h0000);
    wr(`REC_OFS_PAD, 16'h4000);
    @(posedge sys_clk) drv <= 1'b0;
    w(8);
    chk({15'h0000, core_reg_on}, 16'h0001);
    wr(`REC_OFS_PAD, 16'h8000);
    w(3);
    chk({14'h0000, core_reg_on, enable_pin_pulldown}, 16'h0001);
    @(posedge sys_clk) drv <= 1'b1;
    wr(`REC_OFS_ISOLATE, 16'h0001);
    w(2);
    chk({15'h0000, core_domain_isolate}, 16'h0001);
    @(posedge sys_clk) wake_done <= 1'b1;
    @(posedge sys_clk) wake_done <= 1'b0;
    w(2);
    chk({15'h0000, core_domain_isolate}, 16'h0000);
    @(posedge sys_clk) lvl <= 1'b1;
    w(5);
    @(posedge sys_clk) rst_n <= 1'b0;
    @(posedge sys_clk) rst_n <= 1'b1;
    rd(`REC_OFS_PAD, `REC_RST_PAD);
    w(1);
    chk({15'h0000, core_reg_on}, 16'h0001);
    final_report;
  end
endmodule // rec_regulator_enable_control_tb
`default_nettype wire
